/* hdl/cmt_pkg.sv */
// package: register map, field layout and codes of the compare-match timer
package cmt_pkg;

    // ========================================================================
    // bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int IDX_W = 16;
    localparam int IDX_LSB = 2;

    // ========================================================================
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 16'hF700;
    localparam logic [IDX_W-1:0] IDX_IOA = 16'hF701;
    localparam logic [IDX_W-1:0] IDX_CNT = 16'hF706;
    localparam logic [IDX_W-1:0] IDX_GRA = 16'hF708;
    localparam logic [IDX_W-1:0] IDX_START = 16'hF720;
    localparam logic [IDX_W-1:0] IDX_SYNC = 16'hF721;
    localparam logic [IDX_W-1:0] IDX_FUNC = 16'hF723;
    localparam logic [IDX_W-1:0] IDX_OE = 16'hF724;
    localparam logic [IDX_W-1:0] IDX_INIT = 16'hF725;
    localparam logic [IDX_W-1:0] IDX_STAT = 16'hF730;
    localparam logic [IDX_W-1:0] IDX_MASK = 16'hF731;

    // ========================================================================
    // widths and field positions
    localparam int PRESC_W = 13;
    localparam int CNT_W = 16;
    localparam int REG8_W = 8;
    localparam int EVT_W = 2;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 3;
    localparam int EDGE_LSB = 3;
    localparam int EDGE_W = 2;
    localparam int CLR_LSB = 5;
    localparam int CLR_W = 3;
    localparam int IOA_W = 3;
    localparam int CMB_W = 2;
    localparam int BIT0 = 0;
    localparam int EVT_MATCH = 0;
    localparam int EVT_OVF = 1;

    // ========================================================================
    // field codes
    localparam logic [SRC_W-1:0] SRC_CLK = 3'h0;
    localparam logic [SRC_W-1:0] SRC_DIV2 = 3'h1;
    localparam logic [SRC_W-1:0] SRC_DIV4 = 3'h2;
    localparam logic [SRC_W-1:0] SRC_DIV8 = 3'h3;
    localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h0;
    localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h1;
    localparam logic [CLR_W-1:0] CLR_ON_A = 3'h1;
    localparam logic [IOA_W-1:0] IOA_TOGGLE = 3'h1;
    localparam logic [IOA_W-1:0] IOA_LOW = 3'h2;
    localparam logic [IOA_W-1:0] IOA_HIGH = 3'h3;
    localparam logic [CMB_W-1:0] CMB_NORMAL = 2'h0;

    // ========================================================================
    // reset values and counter limits
    localparam logic [REG8_W-1:0] RST_REG8 = 8'h00;
    localparam logic [REG8_W-1:0] RST_OE = 8'hFF;
    localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
    localparam logic [CNT_W-1:0] RST_GRA = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [BE_W-1:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic [REG8_W-1:0] ctrl;
        logic [REG8_W-1:0] ioa;
        logic [REG8_W-1:0] start;
        logic [REG8_W-1:0] sync;
        logic [REG8_W-1:0] func;
        logic [REG8_W-1:0] oe_n;
        logic [REG8_W-1:0] init;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] gra;
        logic [EVT_W-1:0] stat;
        logic [EVT_W-1:0] mask;
        logic [1:0] ext_sync;
        logic src_prev;
        logic level;
        logic seen;
        logic pin;
        logic pin_oe;
        logic irq;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
    } state_t;

endpackage : cmt_pkg

/* hdl/compare_match_toggle_timer.sv */
// compare-match toggle timer channel with avalon-mm register slave
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps

module compare_match_toggle_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [cmt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cmt_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [cmt_pkg::DATA_W-1:0] avs_writedata,
    output logic [cmt_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_clk_pin,
    input wire logic channel1_clear,
    output logic compare_toggle_pin,
    output logic compare_toggle_pin_oe,
    output logic irq
);

    // ========================================================================
    // state
    cmt_pkg::state_t s_r;
    cmt_pkg::state_t s_nxt;
    cmt_pkg::av_req_t req;

    assign req.address = avs_address;
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.byteenable = avs_byteenable;
    assign req.writedata = avs_writedata;

    // ========================================================================
    // byte-lane merge for a register of up to 16 bits
    function automatic logic [cmt_pkg::CNT_W-1:0] merge16(
        input logic [cmt_pkg::CNT_W-1:0] old,
        input logic [cmt_pkg::DATA_W-1:0] wd,
        input logic [cmt_pkg::BE_W-1:0] be
    );
        logic [cmt_pkg::CNT_W-1:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    // ========================================================================
    // next-state logic
    logic [cmt_pkg::IDX_W-1:0] idx;
    logic take;
    logic wr;
    logic wr8;
    logic [cmt_pkg::REG8_W-1:0] wd8;
    logic [cmt_pkg::SRC_W-1:0] src_sel;
    logic [cmt_pkg::EDGE_W-1:0] edge_sel;
    logic [cmt_pkg::CLR_W-1:0] clr_sel;
    logic [cmt_pkg::IOA_W-1:0] ioa_sel;
    logic src_now;
    logic tick;
    logic running;
    logic match;
    logic overflow;
    logic normal;
    logic [cmt_pkg::EVT_W-1:0] evt;
    logic [cmt_pkg::EVT_W-1:0] w1c;
    logic [cmt_pkg::DATA_W-1:0] rd;

    always_comb begin
        s_nxt = s_r;
        idx = req.address[cmt_pkg::IDX_LSB +: cmt_pkg::IDX_W];
        // a request is taken on the edge where waitrequest is seen high; a write lands once it is low
        take = (req.read || req.write) && s_r.waitreq;
        wr = req.write && !s_r.waitreq;
        wr8 = wr && req.byteenable[0];
        wd8 = req.writedata[cmt_pkg::REG8_W-1:0];
        src_sel = s_r.ctrl[cmt_pkg::SRC_LSB +: cmt_pkg::SRC_W];
        edge_sel = s_r.ctrl[cmt_pkg::EDGE_LSB +: cmt_pkg::EDGE_W];
        clr_sel = s_r.ctrl[cmt_pkg::CLR_LSB +: cmt_pkg::CLR_W];
        ioa_sel = s_r.ioa[cmt_pkg::IOA_W-1:0];
        normal = s_r.func[cmt_pkg::CMB_W-1:0] == cmt_pkg::CMB_NORMAL;

        s_nxt.presc = s_r.presc + 1'b1;
        s_nxt.ext_sync = {s_r.ext_sync[0], ext_clk_pin};

        // --------------------------------------------------------------------
        // count source and edge; codes 1xx take the synchronised pin
        case (src_sel)
            cmt_pkg::SRC_CLK: src_now = 1'b0;
            cmt_pkg::SRC_DIV2: src_now = s_r.presc[0];
            cmt_pkg::SRC_DIV4: src_now = s_r.presc[1];
            cmt_pkg::SRC_DIV8: src_now = s_r.presc[2];
            default: src_now = s_r.ext_sync[1];
        endcase
        s_nxt.src_prev = src_now;
        if (src_sel == cmt_pkg::SRC_CLK) begin
            tick = 1'b1;
        end else if (edge_sel == cmt_pkg::EDGE_RISE) begin
            tick = src_now && !s_r.src_prev;
        end else if (edge_sel == cmt_pkg::EDGE_FALL) begin
            tick = !src_now && s_r.src_prev;
        end else begin
            tick = src_now != s_r.src_prev;
        end

        // --------------------------------------------------------------------
        // counter and compare; match is judged on the counting edge so a
        // halted counter parked on the compare value does not re-fire
        running = s_r.start[cmt_pkg::BIT0];
        match = running && tick && (s_r.cnt == s_r.gra);
        overflow = running && tick && (s_r.cnt == cmt_pkg::CNT_MAX);
        if (running && tick) begin
            if (match && clr_sel == cmt_pkg::CLR_ON_A) begin
                s_nxt.cnt = cmt_pkg::RST_CNT;
            end else begin
                s_nxt.cnt = s_r.cnt + cmt_pkg::CNT_ONE;
            end
        end
        if (s_r.sync[cmt_pkg::BIT0] && channel1_clear) begin
            s_nxt.cnt = cmt_pkg::RST_CNT;
        end

        // --------------------------------------------------------------------
        // output action; toggle lands in the same cycle as the clear
        if (match && normal) begin
            s_nxt.seen = 1'b1;
            case (ioa_sel)
                cmt_pkg::IOA_TOGGLE: s_nxt.level = !s_r.level;
                cmt_pkg::IOA_LOW: s_nxt.level = 1'b0;
                cmt_pkg::IOA_HIGH: s_nxt.level = 1'b1;
                default: s_nxt.level = s_r.level;
            endcase
        end

        // --------------------------------------------------------------------
        // register writes; a bus write to the counter wins over counting
        w1c = '0;
        if (wr) begin
            case (idx)
                cmt_pkg::IDX_CTRL: if (wr8) s_nxt.ctrl = wd8;
                cmt_pkg::IDX_IOA: if (wr8) s_nxt.ioa = wd8;
                cmt_pkg::IDX_CNT: begin
                    s_nxt.cnt = merge16(s_r.cnt, req.writedata,
                        req.byteenable);
                end
                cmt_pkg::IDX_GRA: begin
                    s_nxt.gra = merge16(s_r.gra, req.writedata,
                        req.byteenable);
                end
                cmt_pkg::IDX_START: if (wr8) s_nxt.start = wd8;
                cmt_pkg::IDX_SYNC: if (wr8) s_nxt.sync = wd8;
                cmt_pkg::IDX_FUNC: if (wr8) s_nxt.func = wd8;
                cmt_pkg::IDX_OE: if (wr8) s_nxt.oe_n = wd8;
                cmt_pkg::IDX_INIT: begin
                    if (wr8) begin
                        // new initial level holds until the next match
                        s_nxt.init = wd8;
                        s_nxt.level = wd8[cmt_pkg::BIT0];
                        s_nxt.seen = 1'b0;
                    end
                end
                cmt_pkg::IDX_STAT: begin
                    if (wr8) begin
                        w1c = wd8[cmt_pkg::EVT_W-1:0];
                    end
                end
                cmt_pkg::IDX_MASK: begin
                    if (wr8) begin
                        s_nxt.mask = wd8[cmt_pkg::EVT_W-1:0];
                    end
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------------------
        // sticky events: a set in the clearing cycle survives
        evt = '0;
        evt[cmt_pkg::EVT_MATCH] = match;
        evt[cmt_pkg::EVT_OVF] = overflow;
        s_nxt.stat = (s_r.stat & ~w1c) | evt;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

        // --------------------------------------------------------------------
        // pin drive, registered straight to the ports
        s_nxt.pin = s_nxt.seen ? s_nxt.level
            : s_nxt.init[cmt_pkg::BIT0];
        s_nxt.pin_oe = !s_nxt.oe_n[cmt_pkg::BIT0];

        // --------------------------------------------------------------------
        // bus answer: one wait cycle, read data captured as it drops
        rd = '0;
        case (idx)
            cmt_pkg::IDX_CTRL: rd[cmt_pkg::REG8_W-1:0] = s_r.ctrl;
            cmt_pkg::IDX_IOA: rd[cmt_pkg::REG8_W-1:0] = s_r.ioa;
            cmt_pkg::IDX_CNT: rd[cmt_pkg::CNT_W-1:0] = s_r.cnt;
            cmt_pkg::IDX_GRA: rd[cmt_pkg::CNT_W-1:0] = s_r.gra;
            cmt_pkg::IDX_START: rd[cmt_pkg::REG8_W-1:0] = s_r.start;
            cmt_pkg::IDX_SYNC: rd[cmt_pkg::REG8_W-1:0] = s_r.sync;
            cmt_pkg::IDX_FUNC: rd[cmt_pkg::REG8_W-1:0] = s_r.func;
            cmt_pkg::IDX_OE: rd[cmt_pkg::REG8_W-1:0] = s_r.oe_n;
            cmt_pkg::IDX_INIT: rd[cmt_pkg::REG8_W-1:0] = s_r.init;
            cmt_pkg::IDX_STAT: rd[cmt_pkg::EVT_W-1:0] = s_r.stat;
            cmt_pkg::IDX_MASK: rd[cmt_pkg::EVT_W-1:0] = s_r.mask;
            default: rd = '0;
        endcase
        if (take) begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata = req.read ? rd : '0;
        end else begin
            // data bus reads zero outside the answer cycle
            s_nxt.waitreq = 1'b1;
            s_nxt.rdata = '0;
        end
    end

    // ========================================================================
    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r.presc <= '0;
            s_r.ctrl <= cmt_pkg::RST_REG8;
            s_r.ioa <= cmt_pkg::RST_REG8;
            s_r.start <= cmt_pkg::RST_REG8;
            s_r.sync <= cmt_pkg::RST_REG8;
            s_r.func <= cmt_pkg::RST_REG8;
            s_r.oe_n <= cmt_pkg::RST_OE;
            s_r.init <= cmt_pkg::RST_REG8;
            s_r.cnt <= cmt_pkg::RST_CNT;
            s_r.gra <= cmt_pkg::RST_GRA;
            s_r.stat <= '0;
            s_r.mask <= '0;
            s_r.ext_sync <= '0;
            s_r.src_prev <= 1'b0;
            s_r.level <= 1'b0;
            s_r.seen <= 1'b0;
            s_r.pin <= 1'b0;
            s_r.pin_oe <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.waitreq <= 1'b1;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign compare_toggle_pin = s_r.pin;
    assign compare_toggle_pin_oe = s_r.pin_oe;
    assign irq = s_r.irq;

endmodule // compare_match_toggle_timer

/* tb/cmt_load_model.sv */
// partner: load on the toggle pin, measures its half period
`timescale 1ns/1ps
module cmt_load_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin,
    input wire logic pin_oe,
    output int edges,
    output int half
);
    // ========================================================================
    // edge timing
    logic last;
    int cnt;
    // a disabled pin is not seen, so only driven transitions count
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last <= 1'b0;
            cnt <= 0;
            edges <= 0;
            half <= 0;
        end else begin
            last <= pin;
            cnt <= cnt + 1;
            if (pin_oe && pin !== last) begin
                edges <= edges + 1;
                half <= cnt + 1;
                cnt <= 0;
            end
        end
    end
endmodule // cmt_load_model

/* tb/compare_match_toggle_timer_assertions.sv */
// checker: bus handshake and pin/interrupt relations at the ports
`timescale 1ns/1ps
module compare_match_toggle_timer_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [cmt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cmt_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic compare_toggle_pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ========================================================================
    // helpers
    logic mapped;
    assign mapped = avs_address[17:2] inside {cmt_pkg::IDX_CTRL,
        cmt_pkg::IDX_IOA, cmt_pkg::IDX_CNT, cmt_pkg::IDX_GRA,
        cmt_pkg::IDX_START, cmt_pkg::IDX_SYNC, cmt_pkg::IDX_FUNC,
        cmt_pkg::IDX_OE, cmt_pkg::IDX_INIT, cmt_pkg::IDX_STAT,
        cmt_pkg::IDX_MASK};
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    // ========================================================================
    // properties
    property p_take;
        s_take |=> s_answer;
    endproperty
    property p_idle;
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_rd_zero;
        avs_waitrequest |-> avs_readdata == '0;
    endproperty
    property p_rd_width;
        !avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    property p_unmapped;
        !avs_waitrequest && avs_read && !mapped |-> avs_readdata == '0;
    endproperty
    // the enable is only ever moved by a register write
    property p_oe_cause;
        $changed(compare_toggle_pin_oe) |-> $past(avs_write)
            || $past(avs_write, 2);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    property p_rst_out;
        $fell(sys_rst) |-> avs_waitrequest && !compare_toggle_pin_oe && !irq;
    endproperty
    a_take: assert property (p_take) else $error("no single wait");
    a_idle: assert property (p_idle) else $error("spurious ack");
    a_rd_zero: assert property (p_rd_zero) else $error("data idle");
    a_rd_width: assert property (p_rd_width) else $error("width");
    a_unmapped: assert property (p_unmapped) else $error("hole");
    a_oe_cause: assert property (p_oe_cause) else $error("oe");
    a_irq_fall: assert property (p_irq_fall) else $error("irq");
    a_rst_out: assert property (p_rst_out) else $error("reset");
endmodule // compare_match_toggle_timer_assertions

bind compare_match_toggle_timer compare_match_toggle_timer_assertions i_chk (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .compare_toggle_pin_oe, .irq);

/* tb/compare_match_toggle_timer_tb.sv */
// testbench: register access, toggle period, start, interrupt, enable
`timescale 1ns/1ps
module compare_match_toggle_timer_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [17:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_clk_pin = 1'b0;
    logic channel1_clear = 1'b0;
    logic pin;
    logic pin_oe;
    logic irq;
    logic [31:0] seed = 32'hBB34;
    logic [31:0] v;
    logic [15:0] a;
    int edges;
    int half;
    int e0;
    int n;
    int fail_count = 0;
    int tests_run = 0;
    // ========================================================================
    // design and partner
    compare_match_toggle_timer i_dut (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_clk_pin(ext_clk_pin),
        .channel1_clear(channel1_clear), .compare_toggle_pin(pin),
        .compare_toggle_pin_oe(pin_oe), .irq(irq));
    cmt_load_model i_load (.clk(clk), .sys_rst(sys_rst), .pin(pin),
        .pin_oe(pin_oe), .edges(edges), .half(half));
    initial begin
        forever #50 clk = ~clk;
    end
    // ========================================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // clk/2 ticks, clear on match: a full count is a+1 ticks
    function automatic int exp_half(input logic [15:0] av);
        return (int'(av) + 1) * 2;
    endfunction
    // unused inputs still toggle so a wrong sync or source choice shows
    always @(posedge clk) begin
        seed <= lfsr(seed);
        ext_clk_pin <= seed[3];
        channel1_clear <= seed[7];
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [15:0] idx,
        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_byteenable <= be;
        avs_writedata <= wd;
        // no local limit: a hung access is ended by the watchdog
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, 4'h3, wd, d);
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 4'hF, '0, d);
        chk(d, exp);
    endtask
    task automatic waitedge(input int target);
        n = 0;
        while (edges < target && n < 400) begin
            tick(1);
            n++;
        end
        if (edges < target) chk(32'(edges), 32'(target));
    endtask
    initial begin
        tick(20000);
        fail_count++;
        summarize();
    end
    // ========================================================================
    // main sequence
    initial begin
        tick(12);
        sys_rst <= 1'b0;
        tick(1);
        chk(32'(pin_oe), 32'h0);
        rdchk(cmt_pkg::IDX_CNT, 32'h0000);
        rdchk(cmt_pkg::IDX_GRA, 32'hFFFF);
        rdchk(cmt_pkg::IDX_OE, 32'hFF);
        rdchk(16'h0100, 32'h0);
        bus(1'b1, cmt_pkg::IDX_CTRL, 4'hE, 32'hFF, v);
        rdchk(cmt_pkg::IDX_CTRL, 32'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hFFFF0000 : seed;
            wr(cmt_pkg::IDX_CNT, {16'h0, v[15:0]});
            rdchk(cmt_pkg::IDX_CNT, {16'h0, v[15:0]});
            wr(cmt_pkg::IDX_GRA, {16'h0, v[31:16]});
            rdchk(cmt_pkg::IDX_GRA, {16'h0, v[31:16]});
        end
        wr(cmt_pkg::IDX_CTRL, 32'h21);
        wr(cmt_pkg::IDX_IOA, 32'h01);
        wr(cmt_pkg::IDX_FUNC, 32'h00);
        wr(cmt_pkg::IDX_SYNC, 32'h00);
        wr(cmt_pkg::IDX_OE, 32'hFE);
        tick(2);
        chk(32'(pin_oe), 32'h1);
        for (int lvl = 0; lvl < 2; lvl++) begin
            a = 16'h3 + 16'(seed[2:0]);
            wr(cmt_pkg::IDX_START, 32'h0);
            wr(cmt_pkg::IDX_MASK, 32'(1 - lvl));
            wr(cmt_pkg::IDX_GRA, {16'h0, a});
            wr(cmt_pkg::IDX_INIT, 32'(lvl));
            wr(cmt_pkg::IDX_CNT, 32'h0);
            e0 = edges;
            wr(cmt_pkg::IDX_START, 32'h1);
            tick(2);
            chk(32'(pin), 32'(lvl));
            waitedge(e0 + 1);
            tick(1);
            chk(32'(pin), 32'(1 - lvl));
            waitedge(e0 + 3);
            chk(32'(half), 32'(exp_half(a)));
            wr(cmt_pkg::IDX_START, 32'h0);
            bus(1'b0, cmt_pkg::IDX_CNT, 4'hF, '0, v);
            tick(5);
            rdchk(cmt_pkg::IDX_CNT, v);
            chk(32'(irq), 32'(1 - lvl));
            rdchk(cmt_pkg::IDX_STAT, 32'h1);
            wr(cmt_pkg::IDX_STAT, 32'h3);
            tick(2);
            chk(32'(irq), 32'h0);
            rdchk(cmt_pkg::IDX_STAT, 32'h0);
        end
        // sync on: the random channel 1 clears pull the halted counter to 0
        wr(cmt_pkg::IDX_SYNC, 32'h01);
        wr(cmt_pkg::IDX_CNT, 32'h1234);
        tick(40);
        rdchk(cmt_pkg::IDX_CNT, 32'h0);
        wr(cmt_pkg::IDX_SYNC, 32'h00);
        wr(cmt_pkg::IDX_OE, 32'hFF);
        tick(2);
        chk(32'(pin_oe), 32'h0);
        summarize();
    end
endmodule // compare_match_toggle_timer_tb
